// ### hw/synth_host_consts.vh
`ifndef SYNTH_HOST_CONSTS_VH
`define SYNTH_HOST_CONSTS_VH
// Clock rate in kHz, and timing figures in their own units.
`define CLK_KHZ 20000
`define POWER_SETTLE_MS 40
`define CHAN_SETTLE_MS 20
`define MODE_SETTLE_MS 5
`define PREAMBLE_MS 15
`define LOCK_CHECK_MS 20
`define POWER_ON_MS 1
// Serial word layout.
`define WORD_BITS 19
`define WORD_W 5
`define SCLK_HALF 10
// Divider figures for the 25 kHz grid.
`define REF_DIV 14'h0352
`define PRESCALE 64
`define N_BASE 11'h110
`define A_BASE 7'h2C
`define OP_PUMP 1'b0
`define OP_LDPIN 1'b0
`define OP_PHASE 1'b1
// The bit between the head bits and the divider is not used here and is sent low.
`define REF_SPARE 1'b0
// Latch select values of the last bit.
`define SEL_REF 1'b1
`define SEL_PROG 1'b0
// Register offsets of the command port.
`define REG_CTRL 4'h0
`define REG_CHAN 4'h1
`define REG_STATUS 4'h2
// Control register fields.
`define CTRL_POWER 0
`define CTRL_TUNE 1
`define CTRL_TX 2
`define CTRL_RX 3
`define CTRL_PRE 4
`define CHAN_W 8
`endif

// ### hw/serial_word_shifter.v
`timescale 1ns/100ps
// Shifts one 19-bit word out, most significant bit first, then pulses the load strobe.
module serial_word_shifter (
   // Clock and reset
   input wire clock,
   input wire rst_n,
   // Word request
   input wire start,
   input wire [18:0] word,
   output reg busy_ff,
   // Pins
   output reg sclk_ff,
   output reg sdata_ff,
   output reg load_strobe_ff
);
`include "synth_host_consts.vh"
   localparam S_IDLE = 2'h0;
   localparam S_LOW = 2'h1;
   localparam S_HIGH = 2'h2;
   localparam S_LOAD = 2'h3;
   reg [1:0] state_ff;
   reg [18:0] shreg_ff;
   reg [`WORD_W-1:0] bits_ff;
   localparam [3:0] TICK_LAST = `SCLK_HALF - 1;
   localparam [4:0] BIT_LAST = `WORD_BITS - 1;
   reg [3:0] tick_ff;
   wire tick_done = (tick_ff == TICK_LAST);
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= S_IDLE;
         shreg_ff <= 19'h00000;
         bits_ff <= 5'h00;
         tick_ff <= 4'h0;
         busy_ff <= 1'b0;
         sclk_ff <= 1'b0;
         sdata_ff <= 1'b0;
         load_strobe_ff <= 1'b0;
      end else begin
         tick_ff <= (tick_done || state_ff == S_IDLE) ? 4'h0 : tick_ff + 4'h1;
         case (state_ff)
            S_IDLE: begin
               load_strobe_ff <= 1'b0;
               if (start) begin
                  busy_ff <= 1'b1;
                  shreg_ff <= word;
                  bits_ff <= 5'h00;
                  sdata_ff <= word[18];
                  state_ff <= S_LOW;
               end else begin
                  busy_ff <= 1'b0;
               end
            end
            S_LOW: if (tick_done) begin
               sclk_ff <= 1'b1;
               state_ff <= S_HIGH;
            end
            S_HIGH: if (tick_done) begin
               sclk_ff <= 1'b0;
               shreg_ff <= {shreg_ff[17:0], 1'b0};
               sdata_ff <= shreg_ff[17];
               bits_ff <= bits_ff + 5'h01;
               state_ff <= (bits_ff == BIT_LAST) ? S_LOAD : S_LOW;
            end
            S_LOAD: if (tick_done) begin
               // Strobe stays low while bits shift; it rises only after the last bit.
               load_strobe_ff <= 1'b1;
               state_ff <= S_IDLE;
            end
            default: state_ff <= S_IDLE;
         endcase
      end
   end
endmodule // serial_word_shifter

// ### hw/synth_channel_host.v
// What this block does
// - Keep the load strobe low while clocking bits into the synthesizer.
// - Reference and programmable words may go in either order.
// - Drive supply switch and both selects inactive before power on.
// - Wait 40 ms after the first setting before data use.
// - Wait 20 ms after later channel changes before data use.
// - Reload the synthesizer only in receive mode, never transmit.
// - Same-channel switch to receive gives valid data after 5 ms.
// - Transmit may start 5 ms after switching from receive.
// - Check lock indicator high 20 ms after change; ignore earlier glitches.
// - Send alternating one-zero preamble for 15 ms after entering transmit.
// - Extra cold delay up to 20 ms is covered by settle margins.
// - Reference counter value is 850 for 25 kHz comparison.
// - VCO target is channel minus 21.7 MHz.
// - Half-step channels use the grid point below.
// - Prescaler 64; swallow wraps to 0 when programmable counter increments.
// - Reference word head bits: pump 0, lock pin 0, phase 1.
// - Mode selects are active low, one at a time.
// - Keep counters within 11, 7 and 14 bits.
`timescale 1ns/100ps
`include "synth_host_consts.vh"
module synth_channel_host #(
   parameter POWER_SETTLE_CYC = `CLK_KHZ * `POWER_SETTLE_MS,
   parameter CHAN_SETTLE_CYC = `CLK_KHZ * `CHAN_SETTLE_MS,
   parameter MODE_SETTLE_CYC = `CLK_KHZ * `MODE_SETTLE_MS,
   parameter PREAMBLE_CYC = `CLK_KHZ * `PREAMBLE_MS,
   parameter POWER_ON_CYC = `CLK_KHZ * `POWER_ON_MS
) (
   // Clock and reset
   input wire clock,
   input wire rst_n,
   // Command port
   input wire [3:0] addr,
   input wire [31:0] wdata,
   input wire wr,
   input wire rd,
   output reg [31:0] rdata_ff,
   // Synthesizer pins
   output reg sclk_ff,
   output reg sdata_ff,
   output reg load_strobe_ff,
   input wire lock_indicator,
   // Module control pins
   output reg supply_on_ff,
   output reg transmit_select_n_ff,
   output reg receive_select_n_ff,
   output reg tx_data_ff,
   // Status
   output reg link_ready_ff,
   output reg lock_fail_ff
);
   localparam [17:0] PRESCALE_W = `PRESCALE;
   localparam ST_OFF = 3'h0;
   localparam ST_PWR = 3'h1;
   localparam ST_REF = 3'h2;
   localparam ST_PROG = 3'h3;
   localparam ST_SETTLE = 3'h4;
   localparam ST_RX = 3'h5;
   localparam ST_TX = 3'h6;
   reg [2:0] state_ff;
   reg [4:0] ctrl_ff;
   reg [`CHAN_W-1:0] chan_ff;
   reg first_done_ff;
   reg [31:0] wait_ff;
   reg [31:0] pre_ff;
   reg lock_m_ff, lock_s_ff;
   reg start_ff;
   reg [18:0] word_ff;
   reg tune_req_ff;
   reg word_sent_ff;
   wire busy;
   wire sh_sclk, sh_sdata, sh_load;
   // Divider for a channel index: one grid step per two channels, counting up from the first grid point.
   function [17:0] na_for;
      input [`CHAN_W-1:0] ch;
      reg [17:0] n;
      begin
         n = {7'h00, `N_BASE} * PRESCALE_W + {11'h000, `A_BASE} + {11'h000, ch[`CHAN_W-1:1]};
         // The swallow field is 7 bits wide; its top bit stays low because it never reaches 64.
         na_for = {n[16:6], 1'b0, n[5:0]};
      end
   endfunction
   wire [17:0] na = na_for(chan_ff);
   serial_word_shifter u_shift (
      .clock(clock),
      .rst_n(rst_n),
      .start(start_ff),
      .word(word_ff),
      .busy_ff(busy),
      .sclk_ff(sh_sclk),
      .sdata_ff(sh_sdata),
      .load_strobe_ff(sh_load)
   );
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         lock_m_ff <= 1'b0;
         lock_s_ff <= 1'b0;
      end else begin
         lock_m_ff <= lock_indicator;
         lock_s_ff <= lock_m_ff;
      end
   end
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= ST_OFF;
         ctrl_ff <= 5'h00;
         chan_ff <= 8'h00;
         first_done_ff <= 1'b0;
         wait_ff <= 32'h00000000;
         pre_ff <= 32'h00000000;
         start_ff <= 1'b0;
         word_ff <= 19'h00000;
         tune_req_ff <= 1'b0;
         word_sent_ff <= 1'b0;
         rdata_ff <= 32'h00000000;
         sclk_ff <= 1'b0;
         sdata_ff <= 1'b0;
         load_strobe_ff <= 1'b0;
         supply_on_ff <= 1'b0;
         transmit_select_n_ff <= 1'b1;
         receive_select_n_ff <= 1'b1;
         tx_data_ff <= 1'b0;
         link_ready_ff <= 1'b0;
         lock_fail_ff <= 1'b0;
      end else begin
         sclk_ff <= sh_sclk;
         sdata_ff <= sh_sdata;
         load_strobe_ff <= sh_load;
         start_ff <= 1'b0;
         rdata_ff <= 32'h00000000;
         if (wr && addr == `REG_CTRL) begin
            ctrl_ff <= wdata[4:0];
            if (wdata[`CTRL_TUNE])
               tune_req_ff <= 1'b1;
         end
         if (wr && addr == `REG_CHAN)
            chan_ff <= wdata[`CHAN_W-1:0];
         if (rd) begin
            case (addr)
               `REG_CTRL: rdata_ff <= {27'h0000000, ctrl_ff[4:2], 1'b0, ctrl_ff[0]};
               `REG_CHAN: rdata_ff <= {24'h000000, chan_ff};
               `REG_STATUS: rdata_ff <= {26'h0000000, state_ff, lock_s_ff, lock_fail_ff, link_ready_ff};
               default: rdata_ff <= 32'h00000000;
            endcase
         end
         if (wait_ff != 32'h00000000)
            wait_ff <= wait_ff - 32'h00000001;
         word_sent_ff <= busy;
         case (state_ff)
            ST_OFF: if (ctrl_ff[`CTRL_POWER]) begin
               supply_on_ff <= 1'b1;
               receive_select_n_ff <= 1'b0;
               wait_ff <= POWER_ON_CYC;
               state_ff <= ST_PWR;
            end
            ST_PWR: if (wait_ff == 32'h00000000 && tune_req_ff) begin
               link_ready_ff <= 1'b0;
               // Reference word first; the order is free on the far side.
               word_ff <= {`OP_PUMP, `OP_LDPIN, `OP_PHASE, `REF_SPARE, `REF_DIV, `SEL_REF};
               start_ff <= 1'b1;
               state_ff <= ST_REF;
            end
            ST_REF: if (!busy && word_sent_ff && !start_ff) begin
               word_ff <= {na, `SEL_PROG};
               start_ff <= 1'b1;
               state_ff <= ST_PROG;
            end
            ST_PROG: if (!busy && word_sent_ff && !start_ff) begin
               // A new request written in this same cycle must not be lost to the clear.
               if (!(wr && addr == `REG_CTRL && wdata[`CTRL_TUNE]))
                  tune_req_ff <= 1'b0;
               wait_ff <= first_done_ff ? CHAN_SETTLE_CYC : POWER_SETTLE_CYC;
               first_done_ff <= 1'b1;
               state_ff <= ST_SETTLE;
            end
            ST_SETTLE: if (wait_ff == 32'h00000000) begin
               // Glitches before the settle time are ignored; only this sample counts.
               lock_fail_ff <= !lock_s_ff;
               link_ready_ff <= lock_s_ff;
               state_ff <= ST_RX;
            end
            ST_RX: begin
               if (!ctrl_ff[`CTRL_POWER]) begin
                  supply_on_ff <= 1'b0;
                  receive_select_n_ff <= 1'b1;
                  link_ready_ff <= 1'b0;
                  state_ff <= ST_OFF;
               end else if (tune_req_ff) begin
                  state_ff <= ST_PWR;
               end else if (ctrl_ff[`CTRL_TX]) begin
                  receive_select_n_ff <= 1'b1;
                  transmit_select_n_ff <= 1'b0;
                  link_ready_ff <= 1'b0;
                  wait_ff <= MODE_SETTLE_CYC;
                  pre_ff <= ctrl_ff[`CTRL_PRE] ? PREAMBLE_CYC : 32'h00000000;
                  state_ff <= ST_TX;
               end else if (wait_ff == 32'h00000000 && !lock_fail_ff) begin
                  link_ready_ff <= 1'b1;
               end
            end
            ST_TX: begin
               if (pre_ff != 32'h00000000) begin
                  pre_ff <= pre_ff - 32'h00000001;
                  tx_data_ff <= pre_ff[8];
               end else begin
                  tx_data_ff <= 1'b0;
               end
               if (wait_ff == 32'h00000000 && pre_ff == 32'h00000000)
                  link_ready_ff <= 1'b1;
               if (!ctrl_ff[`CTRL_TX]) begin
                  transmit_select_n_ff <= 1'b1;
                  receive_select_n_ff <= 1'b0;
                  link_ready_ff <= 1'b0;
                  tx_data_ff <= 1'b0;
                  wait_ff <= MODE_SETTLE_CYC;
                  state_ff <= ST_RX;
               end
            end
            default: state_ff <= ST_OFF;
         endcase
      end
   end
endmodule // synth_channel_host

// ### tb/synth_host_monitor.sv
`timescale 1ns/100ps
module synth_host_monitor #(
   parameter CHAN_SETTLE_CYC = 50
) (
   // Clock and reset
   input wire clock,
   input wire rst_n,
   // Command port
   input wire [3:0] addr,
   input wire rd,
   input wire [31:0] rdata_ff,
   // Pins
   input wire sclk_ff,
   input wire sdata_ff,
   input wire load_strobe_ff,
   input wire supply_on_ff,
   input wire transmit_select_n_ff,
   input wire receive_select_n_ff,
   // Status
   input wire link_ready_ff,
   input wire lock_fail_ff
);
   reg [15:0] since_ff;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Cycles since the last strobe; saturates so a long idle cannot wrap it.
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) since_ff <= 16'h0000;
      else if (load_strobe_ff) since_ff <= 16'h0000;
      else if (since_ff != 16'hFFFF) since_ff <= since_ff + 16'h0001;
   end
   chk_strobe_low_shift: assert property ($rose(sclk_ff) |-> !load_strobe_ff)
      else $error("strobe high during shift");
   chk_data_clock_low: assert property ($changed(sdata_ff) |-> !sclk_ff)
      else $error("data moved with clock high");
   chk_strobe_clock_low: assert property (load_strobe_ff |-> !sclk_ff)
      else $error("clock high during strobe");
   chk_strobe_pulse_end: assert property ($rose(load_strobe_ff) |-> ##[1:12] !load_strobe_ff)
      else $error("strobe pulse too long");
   chk_one_mode_only: assert property (!(!transmit_select_n_ff && !receive_select_n_ff))
      else $error("both mode selects active");
   chk_off_selects_idle: assert property (!supply_on_ff |-> transmit_select_n_ff && receive_select_n_ff)
      else $error("select active while unpowered");
   chk_no_shift_tx: assert property ($rose(sclk_ff) |-> transmit_select_n_ff)
      else $error("reload during transmit");
   chk_settle_before_ready: assert property ($rose(link_ready_ff) |-> since_ff >= CHAN_SETTLE_CYC - 2)
      else $error("ready before settling");
   chk_status_read: assert property (rd && addr == 4'h2 |=>
      rdata_ff[1:0] == {$past(lock_fail_ff), $past(link_ready_ff)})
      else $error("status read wrong");
   cov_load: cover property ($rose(load_strobe_ff));
   cov_ready: cover property ($rose(link_ready_ff));
   cov_tx: cover property ($fell(transmit_select_n_ff));
endmodule // synth_host_monitor
bind synth_channel_host synth_host_monitor #(.CHAN_SETTLE_CYC(CHAN_SETTLE_CYC)) mon (.clock(clock),
   .rst_n(rst_n), .addr(addr), .rd(rd), .rdata_ff(rdata_ff), .sclk_ff(sclk_ff), .sdata_ff(sdata_ff),
   .load_strobe_ff(load_strobe_ff), .supply_on_ff(supply_on_ff), .transmit_select_n_ff(transmit_select_n_ff),
   .receive_select_n_ff(receive_select_n_ff), .link_ready_ff(link_ready_ff), .lock_fail_ff(lock_fail_ff));

// ### tb/synth_device_model.sv
`timescale 1ns/100ps
module synth_device_model (
   // Clock
   input wire clock,
   // Serial load pins
   input wire sclk,
   input wire sdata,
   input wire load_strobe,
   // Lock control and pin
   input wire lock_en,
   output wire lock_indicator,
   // Latches
   output reg [18:0] ref_latch,
   output reg [18:0] prog_latch,
   output reg [7:0] loads
);
   reg [18:0] shift_ff;
   reg [3:0] wobble_ff;
   initial begin
      shift_ff = 19'h00000;
      ref_latch = 19'h00000;
      prog_latch = 19'h00000;
      loads = 8'h00;
      wobble_ff = 4'h0;
   end
   always @(posedge sclk) shift_ff <= {shift_ff[17:0], sdata};
   // Either word may come first; only the last bit picks the latch.
   always @(posedge load_strobe) begin
      if (shift_ff[0]) ref_latch <= shift_ff;
      else prog_latch <= shift_ff;
      loads <= loads + 8'h01;
   end
   // The indicator chatters after each load, as a loop does before lock.
   always @(posedge clock) begin
      if (load_strobe) wobble_ff <= 4'hF;
      else if (wobble_ff != 4'h0) wobble_ff <= wobble_ff - 4'h1;
   end
   assign lock_indicator = lock_en && (wobble_ff == 4'h0 || wobble_ff[0]);
endmodule // synth_device_model

// ### tb/tb.sv
`timescale 1ns/100ps
`include "synth_host_consts.vh"
module tb;
   reg clock, rst_n, wr, rd, lock_en, t0;
   reg [3:0] addr;
   reg [31:0] wdata;
   wire [31:0] rdata_ff;
   wire sclk_ff, sdata_ff, load_strobe_ff, lock_indicator, supply_on_ff, tx_data_ff;
   wire transmit_select_n_ff, receive_select_n_ff, link_ready_ff, lock_fail_ff;
   wire [18:0] ref_latch, prog_latch;
   wire [7:0] loads;
   integer err_total, checked, cycles, seed, i, ch, w;
   synth_channel_host #(.POWER_SETTLE_CYC(80), .CHAN_SETTLE_CYC(50), .MODE_SETTLE_CYC(50),
      .PREAMBLE_CYC(600), .POWER_ON_CYC(50)) dut (.clock(clock), .rst_n(rst_n), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata_ff(rdata_ff), .sclk_ff(sclk_ff), .sdata_ff(sdata_ff),
      .load_strobe_ff(load_strobe_ff), .lock_indicator(lock_indicator), .supply_on_ff(supply_on_ff),
      .transmit_select_n_ff(transmit_select_n_ff), .receive_select_n_ff(receive_select_n_ff),
      .tx_data_ff(tx_data_ff), .link_ready_ff(link_ready_ff), .lock_fail_ff(lock_fail_ff));
   synth_device_model model (.clock(clock), .sclk(sclk_ff), .sdata(sdata_ff), .load_strobe(load_strobe_ff),
      .lock_en(lock_en), .lock_indicator(lock_indicator), .ref_latch(ref_latch), .prog_latch(prog_latch),
      .loads(loads));
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   task conclude;
      begin
         $display("checks %0d errors %0d", checked, err_total);
         if (err_total == 0 && checked > 0) $display("All tests passed");
         else $display("Some tests failed");
         $finish;
      end
   endtask
   always @(posedge clock) begin
      cycles = cycles + 1;
      if (cycles == 60000) begin
         err_total = err_total + 1;
         conclude;
      end
   end
   task cmp(input string what, input [31:0] exp, input [31:0] got);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            err_total = err_total + 1;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   task wr_reg(input [3:0] a, input [31:0] d);
      begin
         @(posedge clock);
         addr <= a;
         wdata <= d;
         wr <= 1'b1;
         @(posedge clock);
         wr <= 1'b0;
      end
   endtask
   task rd_chk(input [3:0] a, input [31:0] m, input [31:0] e, input string what);
      begin
         @(posedge clock);
         addr <= a;
         rd <= 1'b1;
         @(posedge clock);
         rd <= 1'b0;
         #1 cmp(what, e, rdata_ff & m);
      end
   endtask
   function [18:0] prog_word(input integer c);
      integer n;
      begin
         n = 17452 + c / 2;
         prog_word = {n[16:6], 1'b0, n[5:0], 1'b0};
      end
   endfunction
   task finish_tune(input integer c, input integer w0);
      integer k;
      begin
         for (k = 0; k < 4000 && loads != w0 + 2; k = k + 1) @(posedge clock);
         for (k = 0; k < 400 && link_ready_ff !== 1'b1 && lock_fail_ff !== 1'b1; k = k + 1) @(posedge clock);
         #1 cmp("word count", w0 + 2, loads);
         cmp("prog word", prog_word(c), prog_latch);
         cmp("ref word", {3'b001, 1'b0, 14'h0352, 1'b1}, ref_latch);
      end
   endtask
   task tune(input integer c, input [31:0] ctrl);
      integer w0;
      begin
         wr_reg(`REG_CHAN, c);
         w0 = loads;
         wr_reg(`REG_CTRL, ctrl);
         finish_tune(c, w0);
      end
   endtask
   task mode_ready(input [31:0] ctrl);
      integer k;
      begin
         wr_reg(`REG_CTRL, ctrl);
         repeat (2) @(posedge clock);
         #1 cmp("ready dropped", 0, link_ready_ff);
         for (k = 0; k < 200 && link_ready_ff !== 1'b1; k = k + 1) @(posedge clock);
         #1 cmp("mode ready", 1, link_ready_ff);
      end
   endtask
   initial begin
      seed = 32'h5be90bed;
      err_total = 0;
      checked = 0;
      cycles = 0;
      {rst_n, wr, rd, addr, wdata} = 0;
      lock_en = 1'b1;
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      #1 cmp("idle pins", 3'b011, {supply_on_ff, transmit_select_n_ff, receive_select_n_ff});
      tune(0, 32'h3);
      rd_chk(`REG_STATUS, 32'h7, 32'h5, "status");
      // Channels 39 and 40 sit on both sides of the swallow counter wrap.
      for (i = 0; i < 6; i = i + 1) begin
         ch = (i < 2) ? 39 + i : $unsigned($random(seed)) % 50;
         tune(ch, 32'hB);
      end
      wr_reg(`REG_CTRL, 32'h15);
      #1 t0 = tx_data_ff;
      for (i = 0; i < 900 && tx_data_ff === t0; i = i + 1) @(posedge clock);
      #1 cmp("preamble", !t0, tx_data_ff);
      cmp("tx select", 2'b01, {transmit_select_n_ff, receive_select_n_ff});
      wr_reg(`REG_CHAN, 7);
      w = loads;
      wr_reg(`REG_CTRL, 32'h17);
      repeat (200) @(posedge clock);
      cmp("tx reload held", w, loads);
      wr_reg(`REG_CTRL, 32'h1);
      finish_tune(7, w);
      mode_ready(32'h5);
      mode_ready(32'h1);
      lock_en <= 1'b0;
      tune(20, 32'h3);
      rd_chk(`REG_STATUS, 32'h3, 32'h2, "lock fail");
      lock_en <= 1'b1;
      rd_chk(4'hF, 32'hFFFFFFFF, 32'h0, "unmapped");
      conclude;
   end
endmodule // tb
